// File: verilog/vpc_pkg.sv
// Package with constants and types of the valve position command block
package vpc_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00; // Mode, source, access enable bits
    localparam logic [7:0] OFS_PRESET1   = 8'h04;
    localparam logic [7:0] OFS_PRESET2   = 8'h08;
    localparam logic [7:0] OFS_MANUAL    = 8'h0c; // Manual opening demand
    localparam logic [7:0] OFS_OUTCFG    = 8'h10; // Output select and span
    localparam logic [7:0] OFS_FIELDBUS  = 8'h14; // Fieldbus demand
    localparam logic [7:0] OFS_PIN1      = 8'h18;
    localparam logic [7:0] OFS_PIN2      = 8'h1c;
    localparam logic [7:0] OFS_PIN3      = 8'h20;
    localparam logic [7:0] OFS_LOGIN     = 8'h24; // Write PIN to log in
    localparam logic [7:0] OFS_ACTION    = 8'h28; // Action strobes
    localparam logic [7:0] OFS_STATUS    = 8'h2c;
    localparam logic [7:0] OFS_POSITION  = 8'h30;
    localparam logic [7:0] OFS_STEPLOSS  = 8'h34;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_AUTO_BIT   = 0;
    localparam int CTRL_SRC_LSB    = 1;  // Two bits
    localparam int CTRL_ACC_EN_BIT = 3;
    localparam int ACT_REFRUN_BIT  = 0;
    localparam int ACT_CLRLOSS_BIT = 1;
    localparam int ACT_ERRACK_BIT  = 2;
    localparam int ACT_PINRST_BIT  = 3;
    localparam int ACT_DNLOAD_BIT  = 4;
    localparam int ACT_OPEN_BIT    = 5;
    localparam int ACT_CLOSE_BIT   = 6;
    localparam int OUTCFG_SEL_BIT  = 0;
    localparam int OUTCFG_LO_LSB   = 8;
    localparam int OUTCFG_HI_LSB   = 20;
    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam logic [31:0] RST_CTRL   = 32'h0000_0000; // Manual, access control off
    localparam logic [31:0] RST_OUTCFG = 32'hfff0_0000; // Span 0 to full scale
    localparam logic [15:0] RST_PIN    = 16'h0000;
    localparam int REFRUN_TIME_US = 100;
    localparam int CLK_MHZ        = 100;
    localparam int REFRUN_CYC     = REFRUN_TIME_US * CLK_MHZ;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {SRC_STEP, SRC_VOLT, SRC_CURR, SRC_BUS} vpc_src_t;
    typedef enum logic [1:0] {LVL_READ, LVL_OPER, LVL_SERV, LVL_MAST} vpc_lvl_t;
endpackage

// File: verilog/vpc_scale_if.sv
// Interface carrying position to the output scaler
`timescale 1ns/1ns
`default_nettype none
interface vpc_scale_if #(parameter int PW = 12);
    logic [PW-1:0] pos;
    logic [PW-1:0] lo;
    logic [PW-1:0] hi;
    logic [PW-1:0] value;
    modport master (output pos, output lo, output hi, input value);
    modport slave  (input pos, input lo, input hi, output value);
endinterface
`default_nettype wire

// File: verilog/vpc_scaler.sv
// Linear mapping of opening to analog output code
`timescale 1ns/1ns
`default_nettype none
module vpc_scaler #(
    parameter int PW = 12
) (
    // Clock and reset
    input  wire logic    core_clk,
    input  wire logic    rstn,
    input  wire logic    ce,
    // Data
    vpc_scale_if.slave   sif
);
    logic [2*PW:0] prod;
    logic [PW-1:0] val_r;
    logic          neg;
    logic [PW-1:0] span;
    // Span and product, handles falling mapping too
    always_comb begin
        neg  = sif.hi < sif.lo;
        span = neg ? sif.lo - sif.hi : sif.hi - sif.lo;
        prod = (2*PW+1)'(span) * (2*PW+1)'(sif.pos) + (2*PW+1)'(span); // Ends land exactly on lo and hi
    end
    // Output code registered
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            val_r <= '0;
        end else if (ce) begin
            val_r <= neg ? sif.lo - prod[2*PW-1:PW] : sif.lo + prod[2*PW-1:PW];
        end
    end
    assign sif.value = val_r;
endmodule // vpc_scaler
`default_nettype wire

// File: verilog/vpc_top.sv
// Valve position command and supervision top
`timescale 1ns/1ns
`default_nettype none
module vpc_top #(
    parameter int PW         = 12,
    parameter int REFRUN_CYC = vpc_pkg::REFRUN_CYC
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    // Register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata,
    // Pins
    input  wire logic          pin_pos1,
    input  wire logic          pin_pos2,
    input  wire logic          pin_dir,
    input  wire logic          pin_step,
    input  wire logic          pin_btn_open,
    input  wire logic          pin_btn_close,
    input  wire logic [PW-1:0] adc_volt,
    input  wire logic [PW-1:0] adc_curr,
    input  wire logic          step_loss,
    // Status outputs
    output logic               st_open,
    output logic               st_closed,
    output logic               st_pos1,
    output logic               st_pos2,
    output logic               st_offline,
    output logic [PW-1:0]      pos_out,
    output logic [PW-1:0]      dac_volt,
    output logic [PW-1:0]      dac_curr
);
    localparam logic [PW-1:0] POS_MAX = '1; // Full opening
    localparam int RW = $clog2(REFRUN_CYC + 1);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [5:0] s1_r;
    logic [5:0] s2_r;
    logic [PW-1:0] av1_r, av2_r, ac1_r, ac2_r;
    logic sl1_r, sl2_r, step_d_r;
    // Two stages for every pin
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0; s2_r <= '0; av1_r <= '0; av2_r <= '0;
            ac1_r <= '0; ac2_r <= '0; sl1_r <= 1'b0; sl2_r <= 1'b0; step_d_r <= 1'b0;
        end else if (ce) begin
            s1_r <= {pin_pos1, pin_pos2, pin_dir, pin_step, pin_btn_open, pin_btn_close};
            s2_r <= s1_r;
            av1_r <= adc_volt; av2_r <= av1_r;
            ac1_r <= adc_curr; ac2_r <= ac1_r;
            sl1_r <= step_loss; sl2_r <= sl1_r;
            step_d_r <= s2_r[2];
        end
    end
    logic p1_s, p2_s, dir_s, stp_s, bo_s, bc_s;
    assign {p1_s, p2_s, dir_s, stp_s, bo_s, bc_s} = s2_r;
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0]   ctrl_r, outcfg_r;
    logic [PW-1:0] pre1_r, pre2_r, man_r, bus_r, pos_r;
    logic [15:0]   pin_r [3];
    logic [15:0]   loss_r;
    vpc_pkg::vpc_lvl_t lvl_r;
    logic [RW-1:0] ref_cnt_r;
    logic          refrun;
    logic          err_r;
    logic          acc_en;
    logic          wr_ok_oper, wr_ok_serv, wr_ok_mast;
    logic [31:0]   act;
    assign acc_en = ctrl_r[vpc_pkg::CTRL_ACC_EN_BIT];
    assign refrun = ref_cnt_r != '0;
    assign act    = (reg_wr && reg_addr == vpc_pkg::OFS_ACTION) ? reg_wdata : 32'h0000_0000;
    // Level check; disabled control grants everything
    always_comb begin
        wr_ok_oper = !acc_en || lvl_r >= vpc_pkg::LVL_OPER;
        wr_ok_serv = !acc_en || lvl_r >= vpc_pkg::LVL_SERV;
        wr_ok_mast = !acc_en || lvl_r == vpc_pkg::LVL_MAST;
    end
    // ----------------------------------------
    // Access control
    // ----------------------------------------
    // Login compares PIN against the three stored PINs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lvl_r <= vpc_pkg::LVL_READ;
        end else if (ce) begin
            if (reg_wr && reg_addr == vpc_pkg::OFS_LOGIN) begin
                if (reg_wdata[15:0] == pin_r[2]) lvl_r <= vpc_pkg::LVL_MAST;
                else if (reg_wdata[15:0] == pin_r[1]) lvl_r <= vpc_pkg::LVL_SERV;
                else if (reg_wdata[15:0] == pin_r[0]) lvl_r <= vpc_pkg::LVL_OPER;
                else lvl_r <= vpc_pkg::LVL_READ;
            end
        end
    end
    // PIN storage, one per guarded level
    generate
        for (genvar i = 0; i < 3; i++) begin : g_pin
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    pin_r[i] <= vpc_pkg::RST_PIN;
                end else if (ce && wr_ok_mast) begin
                    if (act[vpc_pkg::ACT_PINRST_BIT]) pin_r[i] <= vpc_pkg::RST_PIN;
                    else if (reg_wr && reg_addr == vpc_pkg::OFS_PIN1 + 8'(4*i)) pin_r[i] <= reg_wdata[15:0];
                end
            end
        end
    endgenerate
    // Control and configuration writes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= vpc_pkg::RST_CTRL;
            outcfg_r <= vpc_pkg::RST_OUTCFG;
            pre1_r <= '0; pre2_r <= '0; man_r <= '0; bus_r <= '0;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                vpc_pkg::OFS_CTRL: begin
                    if (wr_ok_oper) ctrl_r[2:0] <= reg_wdata[2:0];
                    if (wr_ok_mast) ctrl_r[vpc_pkg::CTRL_ACC_EN_BIT] <= reg_wdata[vpc_pkg::CTRL_ACC_EN_BIT];
                end
                vpc_pkg::OFS_PRESET1: if (wr_ok_oper) pre1_r <= reg_wdata[PW-1:0];
                vpc_pkg::OFS_PRESET2: if (wr_ok_oper) pre2_r <= reg_wdata[PW-1:0];
                vpc_pkg::OFS_MANUAL:  if (wr_ok_oper) man_r <= reg_wdata[PW-1:0];
                vpc_pkg::OFS_OUTCFG:  if (wr_ok_mast) outcfg_r <= reg_wdata;
                vpc_pkg::OFS_FIELDBUS: bus_r <= (|reg_wdata[31:PW]) ? '1 : reg_wdata[PW-1:0];
                default: ;
            endcase
        end
    end
    // ----------------------------------------
    // Reference run, errors, step loss
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ref_cnt_r <= RW'(REFRUN_CYC); // Run starts after reset
        end else if (ce) begin
            if (act[vpc_pkg::ACT_REFRUN_BIT] && wr_ok_serv) ref_cnt_r <= RW'(REFRUN_CYC);
            else if (refrun) ref_cnt_r <= ref_cnt_r - 1'b1;
        end
    end
    // Step-loss counter and error flag; set wins over clear, except that a counter saturated at 16'hffff is cleared
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            loss_r <= '0;
            err_r <= 1'b0;
        end else if (ce) begin
            if (sl2_r) err_r <= 1'b1;
            else if (act[vpc_pkg::ACT_ERRACK_BIT] && wr_ok_oper) err_r <= 1'b0;
            if (sl2_r && loss_r != 16'hffff) loss_r <= loss_r + 1'b1;
            else if (act[vpc_pkg::ACT_CLRLOSS_BIT] && wr_ok_serv) loss_r <= '0;
        end
    end
    // ----------------------------------------
    // Position demand and motion
    // ----------------------------------------
    logic          auto_m;
    logic [PW-1:0] src_dem;
    logic          at_open, at_closed;
    assign auto_m    = ctrl_r[vpc_pkg::CTRL_AUTO_BIT];
    assign at_open   = pos_r == POS_MAX;
    assign at_closed = pos_r == '0;
    // Selected automatic source
    always_comb begin
        case (vpc_pkg::vpc_src_t'(ctrl_r[vpc_pkg::CTRL_SRC_LSB +: 2]))
            vpc_pkg::SRC_VOLT: src_dem = av2_r;
            vpc_pkg::SRC_CURR: src_dem = ac2_r;
            vpc_pkg::SRC_BUS:  src_dem = bus_r;
            default:           src_dem = pos_r;
        endcase
    end
    // Track position; buttons move one step a cycle, step pulses one step per rising edge, presets, manual writes and analog and bus sources load directly
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pos_r <= '0;
        end else if (ce && !refrun) begin
            if (p1_s) begin
                pos_r <= pre1_r;
            end else if (p2_s) begin
                pos_r <= pre2_r;
            end else if (!auto_m) begin
                if ((bo_s || (act[vpc_pkg::ACT_OPEN_BIT] && wr_ok_oper)) && !at_open) pos_r <= pos_r + 1'b1;
                else if ((bc_s || (act[vpc_pkg::ACT_CLOSE_BIT] && wr_ok_oper)) && !at_closed)
                    pos_r <= pos_r - 1'b1;
                else if (reg_wr && reg_addr == vpc_pkg::OFS_MANUAL && wr_ok_oper) pos_r <= reg_wdata[PW-1:0];
            end else if (vpc_pkg::vpc_src_t'(ctrl_r[vpc_pkg::CTRL_SRC_LSB +: 2]) == vpc_pkg::SRC_STEP) begin
                if (stp_s && !step_d_r) begin
                    if (dir_s && !at_open) pos_r <= pos_r + 1'b1;
                    else if (!dir_s && !at_closed) pos_r <= pos_r - 1'b1;
                end
            end else begin
                pos_r <= src_dem; // Full code range equals closed to open
            end
        end
    end
    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    vpc_scale_if #(.PW(PW)) sif ();
    assign sif.pos = pos_r;
    assign sif.lo  = outcfg_r[vpc_pkg::OUTCFG_LO_LSB +: PW];
    assign sif.hi  = outcfg_r[vpc_pkg::OUTCFG_HI_LSB +: PW];
    vpc_scaler #(.PW(PW)) u_scaler (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .sif      (sif)
    );
    // Status pins and analog select
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_open <= 1'b0; st_closed <= 1'b0; st_pos1 <= 1'b0; st_pos2 <= 1'b0;
            st_offline <= 1'b1; pos_out <= '0; dac_volt <= '0; dac_curr <= '0;
        end else if (ce) begin
            st_open    <= at_open;
            st_closed  <= at_closed;
            st_pos1    <= pos_r == pre1_r;
            st_pos2    <= pos_r == pre2_r;
            st_offline <= refrun || !auto_m;
            pos_out    <= pos_r;
            dac_volt   <= outcfg_r[vpc_pkg::OUTCFG_SEL_BIT] ? '0 : sif.value;
            dac_curr   <= outcfg_r[vpc_pkg::OUTCFG_SEL_BIT] ? sif.value : '0;
        end
    end
    // Register read, data one cycle after strobe
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    vpc_pkg::OFS_CTRL:     reg_rdata <= ctrl_r;
                    vpc_pkg::OFS_PRESET1:  reg_rdata <= 32'(pre1_r);
                    vpc_pkg::OFS_PRESET2:  reg_rdata <= 32'(pre2_r);
                    vpc_pkg::OFS_MANUAL:   reg_rdata <= 32'(man_r);
                    vpc_pkg::OFS_OUTCFG:   reg_rdata <= outcfg_r;
                    vpc_pkg::OFS_FIELDBUS: reg_rdata <= 32'(bus_r);
                    vpc_pkg::OFS_STATUS:   reg_rdata <= {24'h000000, 2'(lvl_r), err_r, refrun,
                                                         st_pos2, st_pos1, st_closed, st_open};
                    vpc_pkg::OFS_POSITION: reg_rdata <= 32'(pos_r);
                    vpc_pkg::OFS_STEPLOSS: reg_rdata <= 32'(loss_r);
                    default:               reg_rdata <= '0;
                endcase
            end
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    bounds_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && at_open && !p1_s && !p2_s && auto_m && !refrun && dir_s
        && ctrl_r[vpc_pkg::CTRL_SRC_LSB +: 2] == 2'(vpc_pkg::SRC_STEP) |=> pos_r == POS_MAX)
        else $error("position wrapped past open end");
    open_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce |=> st_open == $past(at_open))
        else $error("open status wrong");
    pre_prio_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && p1_s && p2_s && !refrun |=> pos_r == $past(pre1_r))
        else $error("preset one not preferred");
    refrun_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && refrun && !act[vpc_pkg::ACT_REFRUN_BIT] && ref_cnt_r > RW'(1) |=> st_offline && $stable(pos_r))
        else $error("moved during reference run");
    lvl_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && acc_en && lvl_r == vpc_pkg::LVL_READ && reg_wr && reg_addr == vpc_pkg::OFS_PRESET1
        |=> $stable(pre1_r))
        else $error("read-only level changed preset");
    acc_reset_a: assert property (@(posedge core_clk) !rstn |-> !acc_en)
        else $error("access control on in reset");
    cover property (@(posedge core_clk) disable iff (!rstn) st_pos1);
    cover property (@(posedge core_clk) disable iff (!rstn) st_open ##1 !st_open);
    cover property (@(posedge core_clk) disable iff (!rstn) acc_en && lvl_r == vpc_pkg::LVL_MAST);
endmodule // vpc_top
`default_nettype wire

// File: bench/vpc_master_model.sv
// Behavioural master control driving the command pins of the block
`timescale 1ns/1ns
`default_nettype none
module vpc_master_model #(
    parameter int PW = 12
) (
    // Clock
    input  wire logic          core_clk,
    // Demands to the block
    output var  logic          pin_pos1,
    output var  logic          pin_pos2,
    output var  logic          pin_dir,
    output var  logic          pin_step,
    output var  logic [PW-1:0] adc_volt,
    output var  logic [PW-1:0] adc_curr
);
    // Idle demands from time zero
    initial begin
        {pin_pos1, pin_pos2, pin_dir, pin_step} = 4'h0;
        adc_volt = '0;
        adc_curr = '0;
    end
    // Step pulses; gap sets how slowly the master steps
    task automatic steps(input logic dir, input int n, input int gap);
        pin_dir <= dir;
        repeat (n) begin
            repeat (gap) @(posedge core_clk);
            pin_step <= 1'b1;
            repeat (gap) @(posedge core_clk);
            pin_step <= 1'b0;
        end
    endtask
    // Preset select levels
    task automatic set_sel(input logic s1, input logic s2);
        @(posedge core_clk);
        pin_pos1 <= s1;
        pin_pos2 <= s2;
    endtask
    // Analog demands
    task automatic set_adc(input logic [PW-1:0] v, input logic [PW-1:0] c);
        @(posedge core_clk);
        adc_volt <= v;
        adc_curr <= c;
    endtask
endmodule // vpc_master_model
`default_nettype wire

// File: bench/vpc_top_tb_top.sv
// Self-checking testbench of the valve position command block
`timescale 1ns/1ns
`default_nettype none
module vpc_top_tb_top;
    localparam int PW = 12;
    localparam int RR = 8; // Shortened reference run
    // Clock, reset and register port
    logic          core_clk, rstn, reg_wr, reg_rd, btn_o, btn_c, sl;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata, rd;
    // Pins and outputs
    logic          pin_pos1, pin_pos2, pin_dir, pin_step;
    logic          st_open, st_closed, st_pos1, st_pos2, st_offline;
    logic [PW-1:0] adc_volt, adc_curr, pos_out, dac_volt, dac_curr, p;
    int            mismatches, cmp_count;
    // Design and master model
    vpc_top #(.PW(PW), .REFRUN_CYC(RR)) vpc_top_inst (
        .core_clk(core_clk), .rstn(rstn), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_pos1(pin_pos1), .pin_pos2(pin_pos2), .pin_dir(pin_dir), .pin_step(pin_step),
        .pin_btn_open(btn_o), .pin_btn_close(btn_c), .adc_volt(adc_volt),
        .adc_curr(adc_curr), .step_loss(sl), .st_open(st_open), .st_closed(st_closed),
        .st_pos1(st_pos1), .st_pos2(st_pos2), .st_offline(st_offline),
        .pos_out(pos_out), .dac_volt(dac_volt), .dac_curr(dac_curr));
    vpc_master_model #(.PW(PW)) vpc_master_model_inst (
        .core_clk(core_clk), .pin_pos1(pin_pos1), .pin_pos2(pin_pos2), .pin_dir(pin_dir),
        .pin_step(pin_step), .adc_volt(adc_volt), .adc_curr(adc_curr));
    // ----------------------------------------
    // Bus cycles and helpers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("Counts: %0d compared, %0d mismatched", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("offline", 1, st_offline);
        rdr(vpc_pkg::OFS_CTRL);
        chk("ctrl", vpc_pkg::RST_CTRL, rd);
        rdr(vpc_pkg::OFS_OUTCFG);
        chk("outcfg", vpc_pkg::RST_OUTCFG, rd);
        rdr(8'h3c);
        chk("unmapped", 0, rd);
        $display("test reset done");
    endtask
    task automatic t_ends;
        wr(vpc_pkg::OFS_MANUAL, 32'h0000_0fff);
        cyc(6);
        chk("pos open", 12'hfff, pos_out);
        chk("st_open", 1, st_open);
        chk("dac open", 12'hfff, dac_volt);
        wr(vpc_pkg::OFS_MANUAL, 32'h0);
        cyc(6);
        chk("st_closed", 1, st_closed);
        chk("st_open", 0, st_open);
        chk("dac shut", 0, dac_volt);
        wr(vpc_pkg::OFS_FIELDBUS, 32'h0000_5000);
        wr(vpc_pkg::OFS_CTRL, 32'h7);
        cyc(6);
        chk("clamp", 12'hfff, pos_out);
        $display("test ends done");
    endtask
    task automatic t_presets;
        wr(vpc_pkg::OFS_PRESET1, 32'h123);
        wr(vpc_pkg::OFS_PRESET2, 32'h456);
        vpc_master_model_inst.set_sel(1'b0, 1'b1);
        cyc(10);
        chk("preset2", 12'h456, pos_out);
        chk("st_pos2", 1, st_pos2);
        vpc_master_model_inst.set_sel(1'b1, 1'b1);
        cyc(10);
        chk("both", 12'h123, pos_out);
        chk("st_pos1", 1, st_pos1);
        chk("st_pos2", 0, st_pos2);
        vpc_master_model_inst.set_sel(1'b0, 1'b0);
        $display("test presets done");
    endtask
    task automatic t_sources;
        logic [PW-1:0] e;
        vpc_master_model_inst.set_adc(12'h311, 12'h522);
        wr(vpc_pkg::OFS_FIELDBUS, 32'h733);
        for (int i = 1; i < 4; i++) begin
            e = (i == 1) ? 12'h311 : (i == 2) ? 12'h522 : 12'h733;
            wr(vpc_pkg::OFS_CTRL, 32'(1 + 2 * i));
            cyc(10);
            chk("source", e, pos_out);
        end
        $display("test sources done");
    endtask
    task automatic t_steps;
        wr(vpc_pkg::OFS_FIELDBUS, 32'hfff);
        cyc(6);
        wr(vpc_pkg::OFS_CTRL, 32'h1);
        vpc_master_model_inst.steps(1'b1, 3, 2);
        cyc(10);
        chk("step past open", 12'hfff, pos_out);
        vpc_master_model_inst.steps(1'b0, 2, 3);
        cyc(10);
        chk("step back", 12'hffd, pos_out);
        $display("test steps done");
    endtask
    task automatic t_manual;
        wr(vpc_pkg::OFS_CTRL, 32'h0);
        wr(vpc_pkg::OFS_MANUAL, 32'h800);
        wr(vpc_pkg::OFS_FIELDBUS, 32'h100);
        cyc(8);
        chk("manual hold", 12'h800, pos_out);
        @(posedge core_clk);
        btn_o <= 1'b1;
        repeat (20) @(posedge core_clk);
        btn_o <= 1'b0;
        cyc(6);
        p = pos_out;
        chk("button open", 1, p > 12'h800);
        @(posedge core_clk);
        btn_c <= 1'b1;
        repeat (20) @(posedge core_clk);
        btn_c <= 1'b0;
        cyc(6);
        chk("button close", 1, pos_out < p);
        $display("test manual done");
    endtask
    task automatic t_outcfg;
        wr(vpc_pkg::OFS_OUTCFG, 32'h2001_0001);
        wr(vpc_pkg::OFS_MANUAL, 32'h0);
        cyc(6);
        chk("curr low", 12'h100, dac_curr);
        chk("volt off", 0, dac_volt);
        wr(vpc_pkg::OFS_MANUAL, 32'hfff);
        cyc(6);
        chk("curr high", 12'h200, dac_curr);
        wr(vpc_pkg::OFS_OUTCFG, vpc_pkg::RST_OUTCFG);
        $display("test outcfg done");
    endtask
    task automatic t_refrun;
        wr(vpc_pkg::OFS_FIELDBUS, 32'h200);
        wr(vpc_pkg::OFS_CTRL, 32'h7);
        cyc(6);
        chk("auto online", 0, st_offline);
        wr(vpc_pkg::OFS_ACTION, 32'h1);
        wr(vpc_pkg::OFS_FIELDBUS, 32'h300);
        cyc(1);
        chk("run offline", 1, st_offline);
        chk("run frozen", 12'h200, pos_out);
        cyc(RR + 10);
        chk("after run", 12'h300, pos_out);
        $display("test refrun done");
    endtask
    task automatic t_access;
        wr(vpc_pkg::OFS_LOGIN, 32'h0);
        wr(vpc_pkg::OFS_CTRL, 32'h8);
        wr(vpc_pkg::OFS_PIN1, 32'h1111);
        wr(vpc_pkg::OFS_PIN2, 32'h2222);
        wr(vpc_pkg::OFS_PIN3, 32'h3333);
        wr(vpc_pkg::OFS_LOGIN, 32'h9999);
        wr(vpc_pkg::OFS_MANUAL, 32'h500);
        rdr(vpc_pkg::OFS_STATUS);
        chk("level 0", 0, rd[7:6]);
        chk("read only", 12'h300, pos_out);
        wr(vpc_pkg::OFS_LOGIN, 32'h1111);
        wr(vpc_pkg::OFS_MANUAL, 32'h500);
        wr(vpc_pkg::OFS_ACTION, 32'h1);
        rdr(vpc_pkg::OFS_STATUS);
        chk("level 1", 1, rd[7:6]);
        chk("oper no run", 0, rd[4]);
        chk("oper move", 12'h500, pos_out);
        wr(vpc_pkg::OFS_LOGIN, 32'h2222);
        wr(vpc_pkg::OFS_ACTION, 32'h1);
        rdr(vpc_pkg::OFS_STATUS);
        chk("serv run", 1, rd[4]);
        chk("level 2", 2, rd[7:6]);
        wr(vpc_pkg::OFS_OUTCFG, 32'h2001_0001);
        rdr(vpc_pkg::OFS_OUTCFG);
        chk("serv outcfg", vpc_pkg::RST_OUTCFG, rd);
        cyc(RR + 2);
        wr(vpc_pkg::OFS_MANUAL, 32'h600);
        cyc(6);
        chk("serv move", 12'h600, pos_out);
        wr(vpc_pkg::OFS_LOGIN, 32'h3333);
        wr(vpc_pkg::OFS_CTRL, 32'h0);
        rdr(vpc_pkg::OFS_CTRL);
        chk("mast disable", 0, rd);
        wr(vpc_pkg::OFS_LOGIN, 32'h9999);
        wr(vpc_pkg::OFS_MANUAL, 32'h700);
        cyc(6);
        chk("open access", 12'h700, pos_out);
        $display("test access done");
    endtask
    task automatic t_loss;
        @(posedge core_clk);
        sl <= 1'b1;
        repeat (3) @(posedge core_clk);
        sl <= 1'b0;
        wr(vpc_pkg::OFS_LOGIN, 32'h3333);
        wr(vpc_pkg::OFS_CTRL, 32'h8);
        wr(vpc_pkg::OFS_LOGIN, 32'h1111);
        wr(vpc_pkg::OFS_ACTION, 32'h22);
        rdr(vpc_pkg::OFS_STEPLOSS);
        chk("oper no clear", 3, rd);
        chk("oper open step", 12'h701, pos_out);
        rdr(vpc_pkg::OFS_STATUS);
        chk("err set", 1, rd[5]);
        wr(vpc_pkg::OFS_ACTION, 32'h4);
        rdr(vpc_pkg::OFS_STATUS);
        chk("err ack", 0, rd[5]);
        wr(vpc_pkg::OFS_LOGIN, 32'h2222);
        wr(vpc_pkg::OFS_ACTION, 32'h2);
        rdr(vpc_pkg::OFS_STEPLOSS);
        chk("serv clear", 0, rd);
        $display("test loss done");
    endtask
    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        mismatches++;
        $display("[ERR] watchdog expected finish seen timeout");
        give_verdict;
    end
    initial begin
        {rstn, reg_wr, reg_rd, btn_o, btn_c, sl} = 6'h00;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0;
        mismatches = 0;
        cmp_count  = 0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        cyc(RR + 6);
        t_reset;
        t_ends;
        t_presets;
        t_sources;
        t_steps;
        t_manual;
        t_outcfg;
        t_refrun;
        t_access;
        t_loss;
        give_verdict;
    end
endmodule // vpc_top_tb_top
`default_nettype wire
